// ### rtl/rpm_top.sv
/*
 * Reset and power manager: reset gathering, cause flags, low-supply
 * supervision, power modes and shared pin.
 * Assumes a classic Wishbone master, a power-on reset on SYS_RST_I and
 * asynchronous monitor and pin inputs.
 */
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rpm_top
	import rpm_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SYS_RST_I,
	// Wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [3:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic [31:0]      DAT_O,
	output logic             ACK_O,
	// Analogue and pin inputs
	input  wire logic        SUPPLY_LOW_I,
	input  wire logic        RESET_PIN_I,
	input  wire logic        RX_I,
	// Other reset and wake sources
	input  wire logic        WDT_RST_I,
	input  wire logic        IRQ_PENDING_I,
	input  wire logic        KEYPAD_IRQ_I,
	input  wire logic        WAKE_IRQ_I,
	// Outputs
	output logic             CORE_RST_O,
	output logic             LOW_SUPPLY_IRQ_O,
	output logic             CPU_HALT_O,
	output logic             OSC_STOP_O,
	output logic             RC_OSC_STOP_O,
	output logic             LS_DET_ON_O,
	output logic             CMP_ON_O,
	output logic             TIMER_ON_O,
	output logic             WDT_ON_O,
	output logic             RAM_RETAIN_O,
	output logic             PIN_DATA_O
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
		end else begin
			sync_a <= {RX_I, RESET_PIN_I, ~SUPPLY_LOW_I};
			sync_b <= sync_a;
		end
	end
	logic rx_s;
	logic pin_s;
	logic low_s;
	assign rx_s  = sync_b[2];
	assign pin_s = sync_b[1];
	assign low_s = ~sync_b[0];

	// ****************************************
	// Registers and bus
	// ****************************************
	logic [7:0]     ctrl;
	logic [7:0]     next_ctrl;
	logic [5:0]     cause;
	logic [5:0]     next_cause;
	logic           powerup;
	logic           next_powerup;
	logic [7:0]     stretch;
	logic [7:0]     next_stretch;
	logic [5:0]     src_q;
	logic [5:0]     next_src_q;
	rpm_state_t     state;
	rpm_state_t     next_state;
	logic           ack;
	logic           next_ack;
	logic [31:0]    rdata;
	logic [31:0]    next_rdata;
	logic           ls_irq;
	logic           next_ls_irq;
	logic           brk;
	logic [5:0]     src;
	logic           ls_cond;
	logic           pin_as_reset;
	logic           any_src;
	logic           wr;
	logic           rd;
	logic           wr_ctrl;
	logic           wr_cause;
	logic           wr_mode;
	logic [5:0]     rise;

	// ****************************************
	// Decoding
	// ****************************************
	// One decode for every register write, so a strobe hits one register only
	function automatic logic reg_hit(
		input logic [3:0] adr,
		input logic [3:0] sel,
		input logic [3:0] target
	);
		return (adr == target) && sel[0];
	endfunction : reg_hit

	rpm_break_det u_brk (
		.CLK_I     (CLK_I),
		.SYS_RST_I (SYS_RST_I),
		.rx_i      (rx_s),
		.brk_o     (brk)
	);

	assign wr = CYC_I && STB_I && WE_I && !ack;
	assign rd = CYC_I && STB_I && !WE_I && !ack;
	assign wr_ctrl  = wr && reg_hit(ADR_I, SEL_I, REG_CTRL);
	assign wr_cause = wr && reg_hit(ADR_I, SEL_I, REG_CAUSE);
	assign wr_mode  = wr && reg_hit(ADR_I, SEL_I, REG_MODE);

	// Detection off in total power-down, whatever the enable says
	assign ls_cond = ctrl[CTRL_LS_EN] && (state != PM_TPD) && low_s;
	assign pin_as_reset = powerup || ctrl[CTRL_PIN_SEL];

	always_comb begin
		src = 6'h00;
		src[CAUSE_PIN] = pin_as_reset && !pin_s;
		src[CAUSE_LS]  = ls_cond && !ctrl[CTRL_LS_INT];
		src[CAUSE_PWR] = 1'b0;
		src[CAUSE_WDT] = WDT_RST_I;
		src[CAUSE_SW]  = wr_ctrl && DAT_I[CTRL_SW_RST];
		src[CAUSE_BRK] = brk && ctrl[CTRL_BRK_EN];
	end
	assign any_src = |src;

	always_comb begin
		next_ctrl    = ctrl;
		next_cause   = cause;
		next_powerup = powerup;
		next_ack     = CYC_I && STB_I && !ack;
		next_rdata   = rdata;
		next_src_q   = src;
		next_ls_irq  = ls_cond && ctrl[CTRL_LS_INT];
		if (wr_ctrl) begin
			next_ctrl = DAT_I[7:0];
			next_ctrl[CTRL_SW_RST] = 1'b0;
		end
		if (wr_cause) begin
			next_cause = cause & DAT_I[5:0];
			next_powerup = powerup;
		end
		// Set on the first cycle of each source; beats a clear write
		rise = src & ~src_q;
		// A pin held low through power-up belongs to the power-on reset
		if (powerup) begin
			rise[CAUSE_PIN] = 1'b0;
		end
		next_cause = next_cause | rise;
		if (rd) begin
			unique case (ADR_I)
				REG_CTRL:  next_rdata = {24'h000000, ctrl};
				REG_CAUSE: next_rdata = {26'h0000000, cause};
				REG_MODE:  next_rdata = {30'h00000000, state};
				REG_STAT:  next_rdata = {28'h0000000, powerup, pin_s, ls_irq, low_s};
				default:   next_rdata = 32'h00000000;
			endcase
		end
		// Power-up override of the pin ends once the pin is released and the reset stretch has run out
		if (powerup && pin_s && stretch == 8'h00) begin
			next_powerup = 1'b0;
		end
	end

	// ****************************************
	// Reset stretch
	// ****************************************
	always_comb begin
		next_stretch = stretch;
		if (any_src) begin
			next_stretch = 8'(STRETCH_CYC);
		end else if (stretch != 8'h00) begin
			next_stretch = stretch - 8'h01;
		end
	end

	// ****************************************
	// Power mode machine
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			PM_RUN: begin
				if (wr_mode) begin
					unique case (DAT_I[1:0])
						REQ_IDLE: next_state = PM_IDLE;
						REQ_PD:   next_state = PM_PD;
						REQ_TPD:  next_state = PM_TPD;
						default:  next_state = PM_RUN;
					endcase
				end
			end
			PM_IDLE: begin
				if (IRQ_PENDING_I || KEYPAD_IRQ_I || ls_irq) begin
					next_state = PM_RUN;
				end
			end
			PM_PD, PM_TPD: begin
				if (WAKE_IRQ_I || KEYPAD_IRQ_I || (state == PM_PD && ls_irq)) begin
					next_state = PM_RUN;
				end
			end
		endcase
		if (any_src || stretch != 8'h00) begin
			next_state = PM_RUN;
		end
	end

	// ****************************************
	// Bus registers
	// ****************************************
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ack   <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ctrl   <= CTRL_RESET;
			ls_irq <= 1'b0;
		end else begin
			ctrl   <= next_ctrl;
			ls_irq <= next_ls_irq;
		end
	end

	// ****************************************
	// Cause registers
	// ****************************************
	// Only power-on reaches these resets; core resets leave the flags alone
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cause   <= CAUSE_POR_SET;
			powerup <= 1'b1;
			src_q   <= 6'h00;
		end else begin
			cause   <= next_cause;
			powerup <= next_powerup;
			src_q   <= next_src_q;
		end
	end

	// ****************************************
	// Stretch and mode registers
	// ****************************************
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			stretch <= 8'(STRETCH_CYC);
		end else begin
			stretch <= next_stretch;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state <= PM_RUN;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic pd_any;
	assign pd_any = (state == PM_PD) || (state == PM_TPD);

	assign DAT_O            = rdata;
	assign ACK_O            = ack;
	assign CORE_RST_O       = any_src || (stretch != 8'h00);
	assign LOW_SUPPLY_IRQ_O = ls_irq;
	assign CPU_HALT_O       = state != PM_RUN;
	assign OSC_STOP_O       = pd_any;
	assign RC_OSC_STOP_O    = pd_any && !(ctrl[CTRL_RC_SYS] && ctrl[CTRL_TMR_EN]);
	assign LS_DET_ON_O      = ctrl[CTRL_LS_EN] && (state != PM_TPD);
	assign CMP_ON_O         = !ctrl[CTRL_CMP_OFF] && (state != PM_TPD);
	assign TIMER_ON_O       = ctrl[CTRL_TMR_EN];
	assign WDT_ON_O         = 1'b1;
	assign RAM_RETAIN_O     = 1'b1;
	// Pin reads as data only when not used as reset
	assign PIN_DATA_O       = pin_as_reset ? 1'b1 : pin_s;
endmodule : rpm_top
`default_nettype wire

// ### rtl/rpm_pkg.sv
/*
 * Constants, register map and state type of the reset and power manager.
 * Assumes a classic Wishbone slave with 32-bit data, 50 MHz system clock.
 */
// Behaviour
// - Low supply resets the core by default; an option turns it into an interrupt.
// - Software bit enables low-supply detection; when off, low supply does nothing.
// - Internal low-supply condition follows the monitor while detection is enabled.
// - Power-up sets the power-up flag; it stays until software clears it.
// - Idle, power-down and total power-down are entered by software.
// - Idle halts the core; an enabled interrupt or any reset ends it.
// - Power-down stops the oscillator; reset or wake interrupt ends it; RAM kept.
// - In power-down, detector, watchdog, comparators and system timer stay powered.
// - In power-down the RC oscillator stops unless it clocks the system and timer runs.
// - Total power-down also turns off low-supply detection and both comparators.
// - Pin select one makes the shared pin an active-low reset, else plain input.
// - During power-up the shared pin is always a reset; only power-up overrides.
// - Reset sources: pin, power-on, low supply, watchdog, software, receiver break.
// - Each source owns a cause flag; software reads them, writing zero clears.
// - Power-on sets power-up and low-supply flags and clears all others.
// - Other resets set their own flag and keep earlier uncleared flags.
// - Enabled keypad interrupt wakes the core from idle or power-down.
// - Receiver break after 11 consecutive low bit periods may trigger reset.
package rpm_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_CAUSE = 4'h4;
	localparam logic [3:0] REG_MODE  = 4'h8;
	localparam logic [3:0] REG_STAT  = 4'hC;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTRL_LS_EN    = 0;
	localparam int CTRL_LS_INT   = 1;
	localparam int CTRL_PIN_SEL  = 2;
	localparam int CTRL_BRK_EN   = 3;
	localparam int CTRL_SW_RST   = 4;
	localparam int CTRL_RC_SYS   = 5;
	localparam int CTRL_TMR_EN   = 6;
	localparam int CTRL_CMP_OFF  = 7;
	localparam logic [7:0] CTRL_RESET = 8'h01;

	// ****************************************
	// Cause flag positions
	// ****************************************
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_LS  = 1;
	localparam int CAUSE_PWR = 2;
	localparam int CAUSE_WDT = 3;
	localparam int CAUSE_SW  = 4;
	localparam int CAUSE_BRK = 5;
	localparam int CAUSE_W   = 6;
	localparam logic [5:0] CAUSE_POR_SET = 6'h06;

	// ****************************************
	// Mode requests and timing
	// ****************************************
	localparam logic [1:0] REQ_IDLE  = 2'h1;
	localparam logic [1:0] REQ_PD    = 2'h2;
	localparam logic [1:0] REQ_TPD   = 2'h3;
	localparam int CLK_HZ         = 50_000_000;
	localparam int STRETCH_NS     = 200;
	localparam int STRETCH_CYC    = (STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int BRK_BITS       = 11;
	localparam int BAUD_DIV       = 16;
	localparam logic [7:0] BRK_SAMPLES = 8'(BRK_BITS * BAUD_DIV);

	typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PD, PM_TPD} rpm_state_t;

endpackage : rpm_pkg

// ### rtl/rpm_break_det.sv
/*
 * Break detector on the receive line.
 * Assumes the line is already synchronised to CLK_I.
 */
`timescale 1ns/1ps
`default_nettype none
module rpm_break_det
	import rpm_pkg::*;
(
	// Clock and reset
	input  wire logic CLK_I,
	input  wire logic SYS_RST_I,
	// Line
	input  wire logic rx_i,
	output logic      brk_o
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;

	always_comb begin
		next_cnt = cnt;
		if (rx_i) begin
			next_cnt = 8'h00;
		end else if (cnt != BRK_SAMPLES) begin
			next_cnt = cnt + 8'h01;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cnt <= 8'h00;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Fixed oversampling; line held low counts one bit period per BAUD_DIV clocks
	assign brk_o = (cnt == BRK_SAMPLES);
endmodule : rpm_break_det
`default_nettype wire

// ### tb/rpm_monitor.sv
/* Port checker for the reset and power manager.
 * Assumes it is bound into rpm_top and that there is one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rpm_monitor (
	// Clock, reset, bus
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	// Sources
	input wire logic SUPPLY_LOW_I,
	input wire logic WDT_RST_I,
	input wire logic IRQ_PENDING_I,
	input wire logic KEYPAD_IRQ_I,
	input wire logic WAKE_IRQ_I,
	// Power outputs
	input wire logic CORE_RST_O,
	input wire logic LOW_SUPPLY_IRQ_O,
	input wire logic CPU_HALT_O,
	input wire logic OSC_STOP_O,
	input wire logic RC_OSC_STOP_O,
	input wire logic LS_DET_ON_O,
	input wire logic WDT_ON_O,
	input wire logic RAM_RETAIN_O
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
		else $error("ack held too long");
	AST_ACK_NEXT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("no ack after request");
	AST_WDT_RST: assert property (WDT_RST_I |-> CORE_RST_O)
		else $error("watchdog did not reset core");
	AST_STRETCH: assert property ($fell(WDT_RST_I) |-> CORE_RST_O [*8])
		else $error("core reset not stretched");
	AST_IDLE_WAKE: assert property (
		CPU_HALT_O && !OSC_STOP_O && IRQ_PENDING_I |-> ##[1:4] !CPU_HALT_O)
		else $error("idle not ended by interrupt");
	AST_PD_WAKE: assert property (
		OSC_STOP_O && (WAKE_IRQ_I || KEYPAD_IRQ_I) |-> ##[1:4] !OSC_STOP_O)
		else $error("power-down not ended by wake");
	AST_PD_HALT: assert property (OSC_STOP_O |-> CPU_HALT_O)
		else $error("core runs with oscillator stopped");
	AST_RC_RUN: assert property (!OSC_STOP_O |-> !RC_OSC_STOP_O)
		else $error("rc oscillator stopped while running");
	AST_ALWAYS_ON: assert property (WDT_ON_O && RAM_RETAIN_O)
		else $error("watchdog or ram retention off");
	AST_LS_OFF: assert property (!LS_DET_ON_O [*3] |-> !LOW_SUPPLY_IRQ_O)
		else $error("low supply seen while detection off");
	AST_LS_ACT: assert property (
		(LS_DET_ON_O && SUPPLY_LOW_I) [*4] |-> CORE_RST_O || LOW_SUPPLY_IRQ_O)
		else $error("low supply ignored");
endmodule : rpm_monitor
bind rpm_top rpm_monitor u_mon (
	.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
	.SUPPLY_LOW_I(SUPPLY_LOW_I), .WDT_RST_I(WDT_RST_I), .IRQ_PENDING_I(IRQ_PENDING_I),
	.KEYPAD_IRQ_I(KEYPAD_IRQ_I), .WAKE_IRQ_I(WAKE_IRQ_I), .CORE_RST_O(CORE_RST_O),
	.LOW_SUPPLY_IRQ_O(LOW_SUPPLY_IRQ_O), .CPU_HALT_O(CPU_HALT_O), .OSC_STOP_O(OSC_STOP_O),
	.RC_OSC_STOP_O(RC_OSC_STOP_O), .LS_DET_ON_O(LS_DET_ON_O), .WDT_ON_O(WDT_ON_O),
	.RAM_RETAIN_O(RAM_RETAIN_O)
);
`default_nettype wire

// ### tb/rpm_far_side.sv
/* Model of the supply monitor, pin driver and receive line.
 * Assumes the bench commands each event; lines idle at their pulled level. */
`timescale 1ns/1ps
`default_nettype none
module rpm_far_side (
	// Commands
	input  wire logic hold_i,
	input  wire logic dip_i,
	input  wire logic quiet_i,
	input  wire logic fire_i,
	// Lines
	output logic      pin_o,
	output logic      supply_low_o,
	output logic      rx_o,
	output logic      wdt_o
);
	// Pull-up wins once released; only a commanded hold keeps reset
	assign pin_o        = ~hold_i;
	assign supply_low_o = dip_i;
	assign rx_o         = ~quiet_i;
	assign wdt_o        = fire_i;
endmodule : rpm_far_side
`default_nettype wire

// ### tb/test_rpm_top.sv
/* Self-checking bench for the reset and power manager.
 * Assumes rpm_top, rpm_far_side and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module test_rpm_top
	import rpm_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [7:0] dat = 8'h00, rd;
	logic hold = 1'b0, dip = 1'b0, quiet = 1'b0, fire = 1'b0, irq = 1'b0, key = 1'b0, wake = 1'b0;
	logic pin, sup, rx, wdt, ack, core_rst, ls_irq, halt, osc, rc_stop, ls_on, cmp_on, tmr_on;
	logic wdt_on, ram_on, pin_data;
	logic [31:0] dat_o;
	int n_fail = 0;
	int checks_done = 0;
	rpm_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hF), .DAT_I({24'h0, dat}), .DAT_O(dat_o), .ACK_O(ack),
		.SUPPLY_LOW_I(sup), .RESET_PIN_I(pin), .RX_I(rx), .WDT_RST_I(wdt), .IRQ_PENDING_I(irq),
		.KEYPAD_IRQ_I(key), .WAKE_IRQ_I(wake), .CORE_RST_O(core_rst), .LOW_SUPPLY_IRQ_O(ls_irq),
		.CPU_HALT_O(halt), .OSC_STOP_O(osc), .RC_OSC_STOP_O(rc_stop), .LS_DET_ON_O(ls_on),
		.CMP_ON_O(cmp_on), .TIMER_ON_O(tmr_on), .WDT_ON_O(wdt_on), .RAM_RETAIN_O(ram_on),
		.PIN_DATA_O(pin_data));
	rpm_far_side u_far (.hold_i(hold), .dip_i(dip), .quiet_i(quiet), .fire_i(fire),
		.pin_o(pin), .supply_low_o(sup), .rx_o(rx), .wdt_o(wdt));
	initial begin
		forever #10 clk = ~clk;
	end
	// ****************
	// Helpers
	// ****************
	task stop_test;
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Entered just after a rising edge; returns on one
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// Ack and read data are taken at the same rising edge
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task rd_chk(input logic [3:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask : rd_chk
	task wn(input int n);
		repeat (n) @(negedge clk);
	endtask : wn
	task wait_run;
		do @(negedge clk); while (core_rst !== 1'b0);
		@(posedge clk);
	endtask : wait_run
	// ****************
	// Scenarios
	// ****************
	task t_cause;
		rd_chk(REG_CAUSE, 8'h06);
		rd_chk(REG_CTRL, CTRL_RESET);
		rd_chk(4'h2, 8'h00);
		rd_chk(REG_STAT, 8'h04);
		wb(1'b1, REG_CAUSE, 8'h04);
		rd_chk(REG_CAUSE, 8'h04);
		wb(1'b1, REG_CAUSE, 8'h00);
		fire <= 1'b1;
		repeat (2) @(posedge clk);
		fire <= 1'b0;
		wait_run;
		rd_chk(REG_CAUSE, 8'h08);
		wb(1'b1, REG_CTRL, 8'h11);
		wait_run;
		wb(1'b1, REG_CTRL, 8'h05);
		hold <= 1'b1;
		wn(4);
		chk({6'h0, core_rst, pin_data}, 8'h03);
		@(posedge clk);
		hold <= 1'b0;
		wait_run;
		rd_chk(REG_CAUSE, 8'h19);
		wb(1'b1, REG_CAUSE, 8'h00);
		wb(1'b1, REG_CTRL, 8'h01);
		hold <= 1'b1;
		wn(4);
		chk({6'h0, core_rst, pin_data}, 8'h00);
		@(posedge clk);
		hold <= 1'b0;
	endtask : t_cause
	task t_supply;
		dip <= 1'b1;
		wn(5);
		chk({7'h0, core_rst}, 8'h01);
		@(posedge clk);
		dip <= 1'b0;
		wait_run;
		rd_chk(REG_CAUSE, 8'h02);
		wb(1'b1, REG_CTRL, 8'h03);
		dip <= 1'b1;
		wn(5);
		chk({6'h0, core_rst, ls_irq}, 8'h01);
		@(posedge clk);
		dip <= 1'b0;
		wn(5);
		chk({7'h0, ls_irq}, 8'h00);
		@(posedge clk);
		wb(1'b1, REG_CTRL, 8'h02);
		dip <= 1'b1;
		wn(5);
		chk({6'h0, core_rst, ls_irq}, 8'h00);
		@(posedge clk);
		dip <= 1'b0;
		// Let the synchronised low level drain before detection comes back
		wn(3);
		@(posedge clk);
	endtask : t_supply
	task t_modes;
		wb(1'b1, REG_CTRL, 8'h01);
		wb(1'b1, REG_MODE, {6'h0, REQ_IDLE});
		wn(2);
		chk({6'h0, halt, osc}, 8'h02);
		@(posedge clk);
		rd_chk(REG_MODE, {6'h0, REQ_IDLE});
		irq <= 1'b1;
		wn(3);
		chk({7'h0, halt}, 8'h00);
		@(posedge clk);
		irq <= 1'b0;
		wb(1'b1, REG_MODE, {6'h0, REQ_PD});
		wn(2);
		chk({1'b0, osc, rc_stop, ls_on, cmp_on, tmr_on, wdt_on, ram_on}, 8'h7B);
		@(posedge clk);
		key <= 1'b1;
		wn(3);
		chk({7'h0, osc}, 8'h00);
		@(posedge clk);
		key <= 1'b0;
		wb(1'b1, REG_CTRL, 8'h61);
		wb(1'b1, REG_MODE, {6'h0, REQ_TPD});
		wn(2);
		chk({3'h0, osc, rc_stop, ls_on, cmp_on, tmr_on}, 8'h11);
		@(posedge clk);
		wake <= 1'b1;
		wn(3);
		chk({7'h0, osc}, 8'h00);
		@(posedge clk);
		wake <= 1'b0;
		wb(1'b1, REG_MODE, {6'h0, REQ_PD});
		fire <= 1'b1;
		repeat (2) @(posedge clk);
		fire <= 1'b0;
		wait_run;
		chk({6'h0, halt, osc}, 8'h00);
	endtask : t_modes
	task t_break;
		wb(1'b1, REG_CAUSE, 8'h00);
		wb(1'b1, REG_CTRL, 8'h09);
		quiet <= 1'b1;
		repeat (170) @(posedge clk);
		quiet <= 1'b0;
		wn(3);
		chk({7'h0, core_rst}, 8'h00);
		@(posedge clk);
		quiet <= 1'b1;
		repeat (190) @(posedge clk);
		quiet <= 1'b0;
		wait_run;
		rd_chk(REG_CAUSE, 8'h20);
	endtask : t_break
	task t_power_up;
		rst <= 1'b1;
		hold <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wn(20);
		chk({7'h0, core_rst}, 8'h01);
		@(posedge clk);
		hold <= 1'b0;
		wait_run;
		rd_chk(REG_CAUSE, 8'h06);
	endtask : t_power_up
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wait_run;
		t_cause;
		t_supply;
		t_modes;
		t_break;
		t_power_up;
		stop_test;
	end
	// Whole run is under seven hundred cycles; about thirty times that means a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		stop_test;
	end
endmodule : test_rpm_top
`default_nettype wire
